//--- design/ffq_consts.vh
/*
 Constants for the flyback fault qualifier: cycle counts, time figures
 and derived clock counts. Assumes a 100 MHz core clock.
*/
`ifndef FFQ_CONSTS_VH
`define FFQ_CONSTS_VH

`define FFQ_CLK_PERIOD_NS 10
`define FFQ_THERMAL_CYCLES 6'h20
`define FFQ_DIE_CYCLES 6'h20
`define FFQ_SHORT_CYCLES 6'h08
`define FFQ_OVP_CYCLES 6'h03
`define FFQ_LEB_NS 250
// Blanking window in clocks: 250 ns at 10 ns a clock, sized to its counter
`define FFQ_LEB_CLKS 5'h19
`define FFQ_BROWN_MS 45
`define FFQ_BROWN_CLKS (`FFQ_BROWN_MS * 100000)
`define FFQ_CNT_W 6
`define FFQ_LEB_W 5
`define FFQ_BROWN_W 23
// Bit positions of the synchronised comparator levels
`define FFQ_IX_DIS 0
`define FFQ_IX_BO 1
`define FFQ_IX_TH 2
`define FFQ_IX_OVP 3
`define FFQ_IX_DIE 4
`define FFQ_IX_CSLIM 5
`define FFQ_IX_VON 6
`define FFQ_IX_VOFF 7
`define FFQ_IX_VOVLO 8
`define FFQ_IX_VPOR 9

`endif

//--- design/ffq_cycle_qual.v
/*
 Cycle-qualified fault counter: counts switching-cycle strobes while a
 condition holds and reports the fault once the count is reached.
 Assumes strobe and condition are synchronous to mclk.
*/
`include "ffq_consts.vh"

module ffq_cycle_qual (
   input wire mclk,
   input wire rst_b,
   input wire clr,
   input wire cycle_stb,
   input wire cond,
   input wire [`FFQ_CNT_W-1:0] limit,
   output reg hit_ff
);
   reg [`FFQ_CNT_W-1:0] cnt_ff;
   reg [`FFQ_CNT_W-1:0] nxt_cnt;
   reg nxt_hit;

   // Advance per strobe while condition holds, clear when absent
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_hit = hit_ff;
      if (clr) begin
         nxt_cnt = {`FFQ_CNT_W{1'b0}};
         nxt_hit = 1'b0;
      end else if (cycle_stb) begin
         if (!cond) begin
            nxt_cnt = {`FFQ_CNT_W{1'b0}};
            nxt_hit = 1'b0;
         end else if (cnt_ff + 6'h01 >= limit) begin
            nxt_cnt = limit;
            nxt_hit = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 6'h01;
         end
      end
   end

   // State registers
   always @(posedge mclk) begin
      if (!rst_b) begin
         cnt_ff <= {`FFQ_CNT_W{1'b0}};
         hit_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         hit_ff <= nxt_hit;
      end
   end
endmodule // ffq_cycle_qual

//--- design/ffq_fault_qualifier.v
/*
 Fault qualification and switching permission for a flyback controller.
 Takes comparator levels and the PWM cycle strobe; decides when the gate
 drive may run. Comparator inputs are asynchronous and all but cs_over_ctrl pass three flops;
 the gate-on request and cycle strobe come from mclk-domain logic.
 Assumes the variant selects are static straps and that the per-cycle
 strobe arrives once per switching cycle, after the gate request falls.
 A gate pulse only starts on a turn-on edge of the request, so every
 pulse opens a blanking window; a request already high when switching
 becomes permitted waits for its next rising edge.
 The brown-out qualification time is a long clock count; the counter
 stops at its limit and is cleared whenever the line recovers.
 Qualified faults are dropped on leaving the run state, so an
 auto-restart part retries as soon as the supply permits it.
 Latched parts keep a flag that only a power-on level clears.
 The comparator levels carry no hysteresis of their own here; the
 agree stage of each synchroniser rejects single-clock glitches.
*/
`include "ffq_consts.vh"

module ffq_fault_qualifier (
   input wire mclk,
   input wire rst_b,
   input wire variant_brownout,
   input wire variant_latched,
   input wire pwm_gate_req,
   input wire cycle_stb,
   input wire fault_pin_below_disable,
   input wire fault_pin_below_brownout,
   input wire fault_pin_below_thermal,
   input wire fault_pin_above_overvoltage,
   input wire die_over_temp,
   input wire cs_over_limit,
   input wire cs_over_ctrl,
   input wire vdd_above_turn_on,
   input wire vdd_below_turn_off,
   input wire vdd_above_ovlo,
   input wire vdd_below_por,
   output reg gate_drive_output_ff,
   output reg leb_active_ff,
   output reg cs_trip_ff,
   output reg run_ok_ff,
   output reg fault_latched_ff,
   output reg disable_ff,
   output reg brownout_ff
);
   localparam NIN = 10;
   localparam ST_OFF = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_FAULT = 2'h2;

   // Positions of the comparator levels in the synchroniser bank
   localparam IX_DIS = `FFQ_IX_DIS;
   localparam IX_BO = `FFQ_IX_BO;
   localparam IX_TH = `FFQ_IX_TH;
   localparam IX_OVP = `FFQ_IX_OVP;
   localparam IX_DIE = `FFQ_IX_DIE;
   localparam IX_CSLIM = `FFQ_IX_CSLIM;
   localparam IX_VON = `FFQ_IX_VON;
   localparam IX_VOFF = `FFQ_IX_VOFF;
   localparam IX_VOVLO = `FFQ_IX_VOVLO;
   localparam IX_VPOR = `FFQ_IX_VPOR;

   // Input synchroniser stages
   wire [NIN-1:0] raw_in;
   wire [NIN-1:0] sync_in;
   reg [NIN-1:0] s1_ff;
   reg [NIN-1:0] s2_ff;
   reg [NIN-1:0] s3_ff;
   reg [NIN-1:0] st_ff;

   // Sequencer, blanking and brown-out state
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`FFQ_LEB_W-1:0] leb_cnt_ff;
   reg [`FFQ_BROWN_W-1:0] brown_cnt_ff;
   reg gate_prev_ff;
   reg short_seen_ff;
   reg nxt_latched;

   // Qualified faults and decoded conditions
   wire clr_q;
   wire q_therm;
   wire q_die;
   wire q_short;
   wire q_ovp;
   wire disable_now;
   wire brown_now;
   wire ovp_en;
   wire any_fault;
   wire lockout;
   wire turn_on_edge;
   wire gate_allowed;
   wire gate_start;

   // Asynchronous comparator levels, in the order of the index names
   assign raw_in = {vdd_below_por,
      vdd_above_ovlo,
      vdd_below_turn_off,
      vdd_above_turn_on,
      cs_over_limit,
      die_over_temp,
      fault_pin_above_overvoltage,
      fault_pin_below_thermal,
      fault_pin_below_brownout,
      fault_pin_below_disable};

   // Three-flop synchronisers; a change counts once stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
         always @(posedge mclk) begin
            if (!rst_b) begin
               s1_ff[gi] <= 1'b0;
               s2_ff[gi] <= 1'b0;
               s3_ff[gi] <= 1'b0;
               st_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= raw_in[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi])
                  st_ff[gi] <= s3_ff[gi];
            end
         end
      end
   endgenerate
   assign sync_in = st_ff;

   // Disable acts for all variants and releases with no delay
   assign disable_now = sync_in[IX_DIS];
   // Pin-based thermal and overvoltage only in the non brown-out variant
   assign ovp_en = !variant_brownout;
   assign brown_now = variant_brownout && brownout_ff;
   // Supply outside its operating window
   assign lockout = sync_in[IX_VOFF] ||
      sync_in[IX_VOVLO] ||
      sync_in[IX_VPOR];
   // Any qualified fault stops the gate
   assign any_fault = q_therm ||
      q_die ||
      q_short ||
      q_ovp ||
      brown_now;
   assign clr_q = (state_ff != ST_RUN);
   assign turn_on_edge = pwm_gate_req && !gate_prev_ff;

   // Gate permission and the start of a new, blanked pulse
   assign gate_allowed = (nxt_state == ST_RUN) && !disable_now &&
      !any_fault && !lockout;
   assign gate_start = turn_on_edge && run_ok_ff && gate_allowed;

   // Fault pin under its thermal level
   ffq_cycle_qual u_therm (
      .mclk(mclk),
      .rst_b(rst_b),
      .clr(clr_q),
      .cycle_stb(cycle_stb),
      .cond(ovp_en && sync_in[IX_TH]),
      .limit(`FFQ_THERMAL_CYCLES),
      .hit_ff(q_therm)
   );

   // Die above its shutdown temperature
   ffq_cycle_qual u_die (
      .mclk(mclk),
      .rst_b(rst_b),
      .clr(clr_q),
      .cycle_stb(cycle_stb),
      .cond(sync_in[IX_DIE]),
      .limit(`FFQ_DIE_CYCLES),
      .hit_ff(q_die)
   );

   // Short-circuit pulses seen during blanking
   ffq_cycle_qual u_short (
      .mclk(mclk),
      .rst_b(rst_b),
      .clr(clr_q),
      .cycle_stb(cycle_stb),
      .cond(short_seen_ff),
      .limit(`FFQ_SHORT_CYCLES),
      .hit_ff(q_short)
   );

   // Fault pin above its overvoltage level
   ffq_cycle_qual u_ovp (
      .mclk(mclk),
      .rst_b(rst_b),
      .clr(clr_q),
      .cycle_stb(cycle_stb),
      .cond(ovp_en && sync_in[IX_OVP]),
      .limit(`FFQ_OVP_CYCLES),
      .hit_ff(q_ovp)
   );

   // Leading-edge blanking window and short-pulse capture per cycle
   always @(posedge mclk) begin
      if (!rst_b) begin
         leb_cnt_ff <= {`FFQ_LEB_W{1'b0}};
         leb_active_ff <= 1'b0;
         gate_prev_ff <= 1'b0;
         short_seen_ff <= 1'b0;
      end else begin
         gate_prev_ff <= pwm_gate_req;
         if (gate_start) begin
            leb_cnt_ff <= `FFQ_LEB_CLKS;
            leb_active_ff <= 1'b1;
         end else if (leb_cnt_ff > 5'h01) begin
            leb_cnt_ff <= leb_cnt_ff - 5'h01;
         end else begin
            leb_cnt_ff <= {`FFQ_LEB_W{1'b0}};
            leb_active_ff <= 1'b0;
         end
         if (cycle_stb)
            short_seen_ff <= 1'b0;
         else if (leb_active_ff && sync_in[IX_CSLIM])
            short_seen_ff <= 1'b1;
      end
   end

   // Cycle termination compare, masked during blanking
   always @(posedge mclk) begin
      if (!rst_b)
         cs_trip_ff <= 1'b0;
      else
         cs_trip_ff <= cs_over_ctrl && !leb_active_ff;
   end

   // Brown-out timer: line below threshold longer than 45ms
   always @(posedge mclk) begin
      if (!rst_b) begin
         brown_cnt_ff <= {`FFQ_BROWN_W{1'b0}};
         brownout_ff <= 1'b0;
      end else if (!variant_brownout || !sync_in[IX_BO]) begin
         brown_cnt_ff <= {`FFQ_BROWN_W{1'b0}};
         brownout_ff <= 1'b0;
      end else if (brown_cnt_ff >= `FFQ_BROWN_CLKS) begin
         brownout_ff <= 1'b1;
      end else begin
         brown_cnt_ff <= brown_cnt_ff + 23'h000001;
      end
   end

   // Run/fault sequencing with latched or auto-restart response
   always @* begin
      nxt_state = state_ff;
      nxt_latched = fault_latched_ff;
      if (sync_in[IX_VPOR])
         nxt_latched = 1'b0;
      case (state_ff)
         ST_OFF: begin
            if (sync_in[IX_VON] && !lockout && !any_fault && !nxt_latched)
               nxt_state = ST_RUN;
         end
         ST_RUN: begin
            if (lockout)
               nxt_state = ST_OFF;
            else if (any_fault) begin
               nxt_state = ST_FAULT;
               if (variant_latched && !brown_now)
                  nxt_latched = 1'b1;
            end
         end
         ST_FAULT: begin
            if (lockout || !any_fault)
               nxt_state = ST_OFF;
         end
         default: nxt_state = ST_OFF;
      endcase
   end

   // State and output registers
   always @(posedge mclk) begin
      if (!rst_b) begin
         state_ff <= ST_OFF;
         fault_latched_ff <= 1'b0;
         run_ok_ff <= 1'b0;
         disable_ff <= 1'b0;
         gate_drive_output_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         fault_latched_ff <= nxt_latched;
         disable_ff <= disable_now;
         run_ok_ff <= (nxt_state == ST_RUN) && !disable_now;
         gate_drive_output_ff <= gate_start ||
            (gate_drive_output_ff && pwm_gate_req && gate_allowed);
      end
   end
endmodule // ffq_fault_qualifier

//--- testbench/ffq_power_stage.sv
/*
 Model of the switch and current-sense network on the far side.
 Assumes the gate drive is sampled on mclk.
*/
module ffq_power_stage (
   input wire logic mclk,
   input wire logic gate_on,
   input wire logic short_on,
   output logic cs_over_limit,
   output logic cs_over_ctrl
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] on_cnt_ff;
   // On-time of the switch; sensed current ramps while it conducts
   always @(posedge mclk) begin
      on_cnt_ff <= gate_on ? on_cnt_ff + 6'h01 : 6'h00;
   end
   // A shorted output is over the limit at once; a normal ramp
   // crosses the control level only after the blanking window
   assign cs_over_limit = gate_on & short_on;
   assign cs_over_ctrl = gate_on & (on_cnt_ff > 6'h1b);
endmodule // ffq_power_stage

//--- testbench/ffq_monitor.sv
/*
 Concurrent checks on the fault qualifier's ports.
 Assumes one clock, mclk, and the synchronous reset rst_b.
*/
module ffq_monitor (
   input wire mclk,
   input wire rst_b,
   input wire variant_brownout,
   input wire pwm_gate_req,
   input wire cs_over_ctrl,
   input wire gate_drive_output_ff,
   input wire leb_active_ff,
   input wire cs_trip_ff,
   input wire run_ok_ff,
   input wire fault_latched_ff,
   input wire disable_ff,
   input wire brownout_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [5:0] leb_cnt_ff;
   // Cycles spent so far in the current blanking window
   always @(posedge mclk) begin
      if (!rst_b || !leb_active_ff) leb_cnt_ff <= 6'h00;
      else leb_cnt_ff <= leb_cnt_ff + 6'h01;
   end
   gate_start_a: assert property ($rose(gate_drive_output_ff) |->
      $past(pwm_gate_req) && $past(run_ok_ff)) else $error("gate rose");
   stop_when_off_a: assert property (!run_ok_ff[*2] |->
      !gate_drive_output_ff) else $error("gate on while stopped");
   leb_start_a: assert property ($rose(leb_active_ff) |->
      $rose(gate_drive_output_ff)) else $error("blanking start");
   leb_len_a: assert property (leb_active_ff |->
      leb_cnt_ff < 6'h19) else $error("blanking too long");
   trip_masked_a: assert property (cs_trip_ff |->
      $past(cs_over_ctrl) && !$past(leb_active_ff)) else $error("trip");
   disable_stop_a: assert property (disable_ff[*2] |->
      !run_ok_ff && !gate_drive_output_ff) else $error("disable");
   brown_variant_a: assert property (brownout_ff |->
      variant_brownout) else $error("brown-out flag");
   latch_hold_a: assert property (fault_latched_ff[*2] |->
      !run_ok_ff) else $error("latched but running");
endmodule // ffq_monitor
bind ffq_fault_qualifier ffq_monitor i_ffq_monitor (.mclk(mclk),
   .rst_b(rst_b), .variant_brownout(variant_brownout),
   .pwm_gate_req(pwm_gate_req), .cs_over_ctrl(cs_over_ctrl),
   .gate_drive_output_ff(gate_drive_output_ff),
   .leb_active_ff(leb_active_ff), .cs_trip_ff(cs_trip_ff),
   .run_ok_ff(run_ok_ff), .fault_latched_ff(fault_latched_ff),
   .disable_ff(disable_ff), .brownout_ff(brownout_ff));

//--- testbench/tb.sv
/*
 Self-checking bench for the fault qualifier.
 Assumes inputs change at the falling edge of a 100 MHz clock.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst_b, vb, vl, req, stb, dis, bo, th, ov, die, shrt;
   logic von, voff, vovlo, vpor;
   wire gate, leb, trip, run, lat, dis_f, bo_f, cs_lim, cs_ctl;
   int errors, n_compared;
   ffq_fault_qualifier i_ffq_fault_qualifier (.mclk(mclk), .rst_b(rst_b),
      .variant_brownout(vb), .variant_latched(vl), .pwm_gate_req(req),
      .cycle_stb(stb), .fault_pin_below_disable(dis),
      .fault_pin_below_brownout(bo), .fault_pin_below_thermal(th),
      .fault_pin_above_overvoltage(ov), .die_over_temp(die),
      .cs_over_limit(cs_lim), .cs_over_ctrl(cs_ctl),
      .vdd_above_turn_on(von), .vdd_below_turn_off(voff),
      .vdd_above_ovlo(vovlo), .vdd_below_por(vpor),
      .gate_drive_output_ff(gate), .leb_active_ff(leb), .cs_trip_ff(trip),
      .run_ok_ff(run), .fault_latched_ff(lat), .disable_ff(dis_f),
      .brownout_ff(bo_f));
   ffq_power_stage i_ffq_power_stage (.mclk(mclk), .gate_on(gate),
      .short_on(shrt), .cs_over_limit(cs_lim), .cs_over_ctrl(cs_ctl));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic s, input logic e, input string m);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic report_and_stop;
      if (errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic do_reset;
      rst_b = 1'b0;
      repeat (5) @(negedge mclk);
      rst_b = 1'b1;
   endtask
   // Switching cycles: gate request, then one strobe
   task automatic cyc(input int n);
      repeat (n) begin
         req = 1'b1;
         repeat (30) @(negedge mclk);
         req = 1'b0;
         stb = 1'b1;
         @(negedge mclk);
         stb = 1'b0;
         repeat (8) @(negedge mclk);
      end
   endtask
   task automatic wait_run(input logic v);
      for (int k = 0; k < 40 && run !== v; k++) cyc(1);
      chk(run, v, "run state");
   endtask
   task automatic trip_after(input int n, input string m);
      cyc(n - 1);
      chk(run, 1'b1, m);
      req = 1'b1;
      repeat (30) @(negedge mclk);
      req = 1'b0;
      stb = 1'b1;
      @(negedge mclk);
      stb = 1'b0;
      @(negedge mclk);
      chk(run, 1'b0, m);
      repeat (7) @(negedge mclk);
   endtask
   task automatic t_start;
      wait_run(1'b1);
      req = 1'b1;
      repeat (3) @(negedge mclk);
      chk(gate, 1'b1, "gate on");
      chk(leb, 1'b1, "blank on");
      repeat (27) @(negedge mclk);
      chk(leb, 1'b0, "blank off");
      chk(trip, 1'b1, "trip after blank");
      req = 1'b0;
      repeat (3) @(negedge mclk);
   endtask
   task automatic t_faults;
      shrt = 1'b1;
      trip_after(8, "short");
      shrt = 1'b0;
      wait_run(1'b1);
      th = 1'b1;
      trip_after(32, "pin thermal");
      th = 1'b0;
      wait_run(1'b1);
      die = 1'b1;
      trip_after(32, "die thermal");
      die = 1'b0;
      wait_run(1'b1);
      ov = 1'b1;
      cyc(2);
      ov = 1'b0;
      cyc(1);
      ov = 1'b1;
      trip_after(3, "overvoltage");
      ov = 1'b0;
      wait_run(1'b1);
   endtask
   task automatic t_disable;
      dis = 1'b1;
      repeat (6) @(negedge mclk);
      chk(dis_f, 1'b1, "disable");
      chk(run, 1'b0, "disable run");
      dis = 1'b0;
      repeat (6) @(negedge mclk);
      chk(dis_f, 1'b0, "disable exit");
      wait_run(1'b1);
   endtask
   task automatic t_supply;
      vovlo = 1'b1;
      wait_run(1'b0);
      vovlo = 1'b0;
      wait_run(1'b1);
      voff = 1'b1;
      wait_run(1'b0);
      voff = 1'b0;
      wait_run(1'b1);
   endtask
   task automatic t_latch;
      vl = 1'b1;
      do_reset;
      wait_run(1'b1);
      ov = 1'b1;
      cyc(3);
      ov = 1'b0;
      cyc(4);
      chk(run, 1'b0, "latched run");
      chk(lat, 1'b1, "latch flag");
      {von, voff, vpor} = 3'h3;
      cyc(1);
      {von, voff, vpor} = 3'h4;
      wait_run(1'b1);
   endtask
   task automatic t_brown;
      {vl, vb, dis} = 3'h3;
      do_reset;
      cyc(10);
      chk(run, 1'b0, "floating pin");
      chk(bo_f, 1'b0, "brown-out flag");
      dis = 1'b0;
      wait_run(1'b1);
   endtask
   // Main sequence
   initial begin
      {rst_b, vb, vl, req, stb, dis, bo, th, ov, die, shrt} = 11'h0;
      {von, voff, vovlo, vpor} = 4'h8;
      errors = 0;
      n_compared = 0;
      @(negedge mclk);
      do_reset;
      t_start;
      t_faults;
      t_disable;
      t_supply;
      t_latch;
      t_brown;
      report_and_stop;
   end
   // Watchdog
   initial begin
      repeat (90000) @(posedge mclk);
      errors++;
      report_and_stop;
   end
endmodule // tb
